/* File: logic/acp_pkg.sv */
// Shared constants for the conversion-control and parallel-output port
package acp_pkg;

  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TYP_NS   = 240;
  localparam int CONV_MAX_NS   = 283;
  localparam int ACQ_MAX_NS    = 50;
  localparam int THRU_NS       = 333;

  // Conversion is a least time towards the typical figure, kept under the maximum
  localparam int CONV_CYC = (CONV_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC  = (ACQ_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : ACQ_MAX_NS / CLK_PERIOD_NS;
  localparam int THRU_CYC = THRU_NS / CLK_PERIOD_NS;

  localparam int CNT_W       = 4;
  localparam int RES_W       = 12;
  localparam int FIFO_DEPTH  = 16;
  localparam logic [RES_W-1:0] DATA_RST = 12'h000;

  typedef enum logic [1:0] {
    ACP_IDLE,
    ACP_CONV,
    ACP_ACQ
  } acp_state_e;

endpackage : acp_pkg

/* File: logic/acp_stream_if.sv */
// Valid/ready word stream between the port logic and its result buffer
`timescale 1ns/100ps
`default_nettype none
interface acp_stream_if #(
  parameter int WIDTH = 12
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : acp_stream_if
`default_nettype wire

/* File: logic/acp_fifo.sv */
// Result buffer: word FIFO with registered read data
`timescale 1ns/100ps
`default_nettype none
module acp_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic   mclk_i,
  input  wire logic   reset_n_i,
  acp_stream_if.snk   wr_s,
  acp_stream_if.src   rd_s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic [WIDTH-1:0] dout_r;
  logic             dout_vld_r;

  wire mem_full  = (count_r == (AW+1)'(DEPTH));
  wire mem_empty = (count_r == '0);
  wire push      = wr_s.valid && !mem_full;
  wire load      = !mem_empty && (!dout_vld_r || rd_s.ready);

  assign wr_s.ready = !mem_full;
  assign rd_s.valid = dout_vld_r;
  assign rd_s.data  = dout_r;

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= wr_s.data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      wr_ptr_r   <= '0;
      rd_ptr_r   <= '0;
      count_r    <= '0;
      dout_r     <= '0;
      dout_vld_r <= 1'b0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (load) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
        dout_r   <= mem[rd_ptr_r];
      end
      count_r    <= count_r + (AW+1)'(push) - (AW+1)'(load);
      dout_vld_r <= load || (dout_vld_r && !rd_s.ready);
    end
  end

  a_full_refuse: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (count_r == (AW+1)'(DEPTH)) |-> !wr_s.ready)
    else $error("fifo accepts while full");

  a_out_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (rd_s.valid && !rd_s.ready) |=> (rd_s.valid && $stable(rd_s.data)))
    else $error("fifo output dropped under stall");

  a_count_bound: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    count_r <= (AW+1)'(DEPTH))
    else $error("fifo count overflow");
endmodule : acp_fifo
`default_nettype wire

/* File: logic/acp_conv_port.sv */
// Conversion control, status and parallel result port of a 12-bit sampling converter
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Select low drives the data bus and lets convert-start through.
// - A falling convert-start while selected begins a conversion when idle and the result buffer has room.
// - Convert-start edges during a conversion are ignored.
// - Status is low for the whole conversion, high when done.
// - Conversion is internally timed, about 240ns, never over 283ns.
// - Acquisition before a conversion lasts no more than 50ns.
// - One acquire-and-convert cycle fits in 333ns, for 3Msps.
// - Output register takes the new result as status rises.
// - Data latched as status falls belongs to the previous conversion.
// - Result is 12-bit two's complement, one step is span over 4096.
module acp_conv_port
  import acp_pkg::*;
#(
  parameter int RES_WIDTH  = RES_W,
  parameter int BUF_DEPTH  = FIFO_DEPTH
) (
  input  wire logic                 mclk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 select_n_i,
  input  wire logic                 conversion_start_n_i,
  input  wire logic [RES_WIDTH-1:0] sample_code_i,
  output logic                      busy_n_o,
  output logic                      hold_o,
  output logic [RES_WIDTH-1:0]      data_o,
  output logic                      data_oe_n_o,
  output logic                      result_valid_o,
  output logic [RES_WIDTH-1:0]      result_data_o,
  input  wire logic                 result_ready_i
);

  acp_state_e           state_r;
  acp_state_e           state_nxt;
  logic [CNT_W-1:0]     cnt_r;
  logic [CNT_W-1:0]     cnt_nxt;
  logic                 start_n_prev_r;
  logic                 busy_n_r;
  logic [RES_WIDTH-1:0] data_r;

  acp_stream_if #(.WIDTH(RES_WIDTH)) push_s ();
  acp_stream_if #(.WIDTH(RES_WIDTH)) pop_s ();

  // Edge seen only while selected
  wire start_fall = !select_n_i && start_n_prev_r && !conversion_start_n_i;
  // Starts are taken only when idle and the buffer has room
  wire start_ok   = start_fall && (state_r == ACP_IDLE) && push_s.ready;
  wire cnt_zero   = (cnt_r == '0);
  wire conv_done  = (state_r == ACP_CONV) && cnt_zero;
  wire acq_done   = (state_r == ACP_ACQ) && cnt_zero;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_zero ? cnt_r : cnt_r - 1'b1;
    unique case (state_r)
      ACP_IDLE: begin
        if (start_ok) begin
          state_nxt = ACP_CONV;
          cnt_nxt   = CNT_W'(CONV_CYC - 1);
        end
      end
      ACP_CONV: begin
        if (cnt_zero) begin
          state_nxt = ACP_ACQ;
          cnt_nxt   = CNT_W'(ACQ_CYC - 1);
        end
      end
      ACP_ACQ: begin
        if (cnt_zero) begin
          state_nxt = ACP_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      state_r        <= ACP_IDLE;
      cnt_r          <= '0;
      start_n_prev_r <= 1'b1;
      busy_n_r       <= 1'b1;
    end else begin
      state_r        <= state_nxt;
      cnt_r          <= cnt_nxt;
      start_n_prev_r <= conversion_start_n_i;
      busy_n_r       <= (state_nxt != ACP_CONV);
    end
  end

  // Result register changes only as status rises
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      data_r <= DATA_RST;
    end else if (conv_done) begin
      data_r <= sample_code_i;
    end
  end

  assign push_s.valid = conv_done;
  assign push_s.data  = sample_code_i;

  acp_fifo #(
    .WIDTH (RES_WIDTH),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .wr_s      (push_s),
    .rd_s      (pop_s)
  );

  assign pop_s.ready    = result_ready_i;
  assign result_valid_o = pop_s.valid;
  assign result_data_o  = pop_s.data;

  assign busy_n_o    = busy_n_r;
  assign hold_o      = !busy_n_r;
  assign data_o      = data_r;
  assign data_oe_n_o = select_n_i;

  // Helper: cycles since status fell
  logic [CNT_W:0] low_cnt_r;
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      low_cnt_r <= '0;
    end else begin
      low_cnt_r <= busy_n_r ? '0 : low_cnt_r + 1'b1;
    end
  end

  a_bus_drive: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (select_n_i == data_oe_n_o))
    else $error("data bus enable does not follow select");

  a_deselect_ignore: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (select_n_i && busy_n_o && (state_r == ACP_IDLE)) |=> busy_n_o)
    else $error("conversion started while deselected");

  a_start_taken: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    start_ok |=> !busy_n_o ##1 !busy_n_o)
    else $error("accepted start did not begin a conversion");

  a_no_restart: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (!busy_n_o && (low_cnt_r < (CNT_W+1)'(CONV_CYC - 1))) |=> !busy_n_o)
    else $error("conversion cut short or restarted");

  a_conv_length: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $fell(busy_n_o) |-> (!busy_n_o)[*8] ##1 !busy_n_o ##1 !busy_n_o ##1 busy_n_o)
    else $error("status low time is not the conversion time");

  a_conv_max: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    low_cnt_r <= (CNT_W+1)'(CONV_MAX_CYC))
    else $error("conversion exceeds maximum time");

  a_acq_bound: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(busy_n_o) |-> ##[1:2] (state_r == ACP_IDLE))
    else $error("acquisition too long for throughput");

  a_data_on_rise: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    $rose(busy_n_o) |-> (data_o == $past(sample_code_i)))
    else $error("result not loaded as status rises");

  a_data_hold: assert property (@(posedge mclk_i) disable iff (!reset_n_i)
    (!busy_n_o || $past(busy_n_o)) |-> $stable(data_o))
    else $error("result changed away from end of conversion");

endmodule : acp_conv_port
`default_nettype wire

/* File: tb/acp_host_model.sv */
// Host side model: latches the parallel bus and drains the result stream
`timescale 1ns/100ps
`default_nettype none
module acp_host_model (
  input  wire logic        mclk_i,
  input  wire logic        busy_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [11:0] data_i,
  input  wire logic        valid_i,
  input  wire logic [11:0] word_i,
  input  wire logic        stall_i,
  output logic             ready_o,
  output logic             got_o,
  output logic [11:0]      got_word_o,
  output logic [11:0]      lat_o
);
  logic        ph_r = 1'b0;
  logic [11:0] bus_seen;
  // Buffered bus reads as the inverse of the port while released
  assign bus_seen = oe_n_i ? ~data_i : data_i;
  // Host stays idle while a conversion runs
  assign ready_o = ~stall_i & ph_r & busy_n_i;
  always @(posedge mclk_i) begin
    ph_r       <= ~ph_r;
    got_o      <= valid_i & ready_o;
    got_word_o <= word_i;
  end
  // Latch on the status fall, never on its rise
  always @(negedge busy_n_i) lat_o <= bus_seen;
endmodule : acp_host_model
`default_nettype wire

/* File: tb/tb_adc_parallel_conversion_port.sv */
// Self-checking bench of the conversion port
`timescale 1ns/100ps
`default_nettype none
module tb_adc_parallel_conversion_port;
  import acp_pkg::*;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, select_n_i = 1'b1, conversion_start_n_i = 1'b1;
  logic [11:0] sample_code_i = 12'h000, data_o, result_data_o, got_word, lat, last;
  logic busy_n_o, hold_o, data_oe_n_o, result_valid_o, result_ready_i, got, stall;
  int fail_count = 0, checks_done = 0, n = 0;
  logic [31:0] x = 32'd56046;
  logic [11:0] exp_q[$];
  always #12.5 mclk_i = ~mclk_i;
  acp_conv_port i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .select_n_i(select_n_i),
    .conversion_start_n_i(conversion_start_n_i), .sample_code_i(sample_code_i),
    .busy_n_o(busy_n_o), .hold_o(hold_o), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
    .result_valid_o(result_valid_o), .result_data_o(result_data_o),
    .result_ready_i(result_ready_i));
  acp_host_model i_host (.mclk_i(mclk_i), .busy_n_i(busy_n_o), .oe_n_i(data_oe_n_o),
    .data_i(data_o),
    .valid_i(result_valid_o), .word_i(result_data_o), .stall_i(stall),
    .ready_o(result_ready_i), .got_o(got), .got_word_o(got_word), .lat_o(lat));
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task conv(input logic sel);
    int lo;
    logic [11:0] c, prev;
    logic acc;
    lo = 0;
    c = (n == 0) ? 12'h800 : (n == 1) ? 12'h7ff : 12'(rnd());
    n++;
    prev = last;
    acc = !sel && exp_q.size() < FIFO_DEPTH + 1;
    @(negedge mclk_i);
    select_n_i = sel;
    sample_code_i = c;
    conversion_start_n_i = 1'b0;
    // Next start falls THRU_CYC cycles (325ns) later, within one throughput period
    for (int i = 0; i < THRU_CYC - 1; i++) begin
      @(negedge mclk_i);
      if (busy_n_o === 1'b0) lo++;
      if (i == 0) check(data_oe_n_o, sel);
      if (i == 1) check(hold_o, acc);
      // Start attempts in mid-conversion and in acquisition
      conversion_start_n_i = (i == 4 || i == 10) ? 1'b0 : 1'b1;
    end
    check(lo, acc ? CONV_CYC : 0);
    if (acc) begin
      exp_q.push_back(c);
      last = c;
      check(lat, prev);
    end
    check(data_o, last);
  endtask : conv
  // Stream words in conversion order
  always @(negedge mclk_i) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) check(1, 0);
      else check(got_word, exp_q.pop_front());
    end
  end
  initial begin
    last = DATA_RST;
    stall = 1'b0;
    repeat (8) @(negedge mclk_i);
    reset_n_i = 1'b1;
    check(busy_n_o, 1'b1);
    check(data_o, DATA_RST);
    for (int k = 0; k < 10; k++) conv(k < 2 ? 1'b0 : 1'(rnd()));
    stall = 1'b1;
    for (int k = 0; k < 18; k++) conv(1'b0);
    stall = 1'b0;
    repeat (80) @(negedge mclk_i);
    check(exp_q.size(), 0);
    end_sim();
  end
  initial begin
    #(5000 * CLK_PERIOD_NS);
    fail_count++;
    end_sim();
  end
endmodule : tb_adc_parallel_conversion_port
`default_nettype wire
